// ### verilog/ped_params.svh
/*
  constants for the page entry permission decoder: entry field
  positions, widths and reset values.
  assumes it is included by bare name from the package and the decoder.
*/
// Notes on behaviour
// - no-exec enable plus bit 63 denies execute
// - bits haw-1 down to 12 give frame
// - nested enable marks frame as guest physical
// - bit 10 extended-accessed only when enabled
// - bit 8 marks global when global enabled
// - coherent requesters take memory type from 7,4,3
// - set bit 6 after granted write
// - set bit 5 when entry used
// - bit 2 clear refuses user requests
// - bit 1 clear denies user, protected supervisor writes
// - bit 0 must be set to map
// - second-level execute ignored unless supported and enabled
// - second-level memory type ignored unless supported, enabled
// - report large page support in capability field
`ifndef PED_PARAMS_SVH
`define PED_PARAMS_SVH
`define PED_ENTRY_W     64
`define PED_HAW         48
`define PED_FRAME_LSB   12
`define PED_FRAME_W     (`PED_HAW - `PED_FRAME_LSB)
`define PED_RSVD_MSB    51
`define PED_BIT_XD      63
`define PED_BIT_EXTACC  10
`define PED_BIT_GLOBAL  8
`define PED_BIT_ATTR    7
`define PED_BIT_DIRTY   6
`define PED_BIT_ACC     5
`define PED_BIT_PCD     4
`define PED_BIT_PWT     3
`define PED_BIT_US      2
`define PED_BIT_RW      1
`define PED_BIT_P       0
`define PED_SL_IGNORE_ATTR_BIT     6
`define PED_SL_EMT_MSB  5
`define PED_SL_EMT_LSB  3
`define PED_SL_X        2
`define PED_SL_PS       7
`define PED_LP_SUPPORT  2'h3
`define PED_ENTRY_RST   64'h0000_0000_0000_0000
`endif

// ### verilog/ped_pkg.sv
/*
  types for the page entry permission decoder.
  assumes ped_params.svh sits on the include path.
*/
`include "ped_params.svh"
package ped_pkg;
  // whole registered state of the decoder
  typedef struct packed {
    logic                      resp_valid;
    logic                      present_ok;
    logic                      malformed;
    logic                      granted;
    logic [`PED_FRAME_W-1:0]   frame_addr;
    logic                      frame_is_gpa;
    logic                      exec_allowed;
    logic                      write_allowed;
    logic                      user_allowed;
    logic                      global_page;
    logic [2:0]                attr_idx;
    logic                      attr_valid;
    logic [`PED_ENTRY_W-1:0]   updated_entry;
    logic                      entry_update;
    logic                      sl_exec_allowed;
    logic [2:0]                sl_emt;
    logic                      sl_ignore_attr;
    logic                      sl_emt_valid;
    logic                      sl_large_page;
    logic [1:0]                lp_support;
  } ped_state_t;
endpackage : ped_pkg

// ### verilog/ped_page_entry_decode.sv
/*
  decodes a first-level 4-kbyte leaf entry and a second-level entry
  for one translation request, answering one cycle later.
  assumes all inputs come from logic on clk_in; the walker writes back
  updated_entry_out when entry_update_out is high.
*/
`timescale 1ns/1ps
`include "ped_params.svh"
module ped_page_entry_decode (
  // clock, reset, enable
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      clk_en_in,
  // request and first-level leaf entry
  input  wire logic                      req_valid_in,
  input  wire logic [`PED_ENTRY_W-1:0]   entry_in,
  input  wire logic                      user_req_in,
  input  wire logic                      write_req_in,
  input  wire logic                      exec_req_in,
  input  wire logic                      coherent_req_in,
  // governing context controls
  input  wire logic                      no_exec_enable_in,
  input  wire logic                      nested_translate_enable_in,
  input  wire logic                      ext_accessed_flag_enable_in,
  input  wire logic                      global_page_enable_in,
  input  wire logic                      write_protect_enable_in,
  // second-level entry and controls
  input  wire logic [`PED_ENTRY_W-1:0]   sl_entry_in,
  input  wire logic                      sl_dir_level_in,
  input  wire logic                      exec_request_support_in,
  input  wire logic                      second_level_exec_enable_in,
  input  wire logic                      mem_type_support_in,
  input  wire logic                      mem_type_enable_in,
  // first-level results
  output logic                           resp_valid_out,
  output logic                           present_ok_out,
  output logic                           malformed_out,
  output logic                           granted_out,
  output logic [`PED_FRAME_W-1:0]        frame_addr_out,
  output logic                           frame_is_gpa_out,
  output logic                           exec_allowed_out,
  output logic                           write_allowed_out,
  output logic                           user_allowed_out,
  output logic                           global_out,
  output logic [2:0]                     attr_idx_out,
  output logic                           attr_valid_out,
  output logic [`PED_ENTRY_W-1:0]        updated_entry_out,
  output logic                           entry_update_out,
  // second-level results
  output logic                           sl_exec_allowed_out,
  output logic [2:0]                     sl_emt_out,
  output logic                           sl_ignore_attr_out,
  output logic                           sl_emt_valid_out,
  output logic                           sl_large_page_out,
  // capability
  output logic [1:0]                     large_page_support_out
);

  ped_pkg::ped_state_t state_reg;   // registered state
  ped_pkg::ped_state_t state_next;  // next state

  // decode helpers
  logic rsvd_nz;     // reserved bits nonzero
  logic present;     // entry maps a page
  logic exec_ok;     // execute permitted
  logic write_ok;    // write permitted
  logic user_ok;     // privilege permitted
  logic grant;       // request fully translated

  // permission and shape decode
  always_comb begin
    rsvd_nz  = |entry_in[`PED_RSVD_MSB:`PED_HAW];
    present  = entry_in[`PED_BIT_P];
    exec_ok  = !(no_exec_enable_in
                 && entry_in[`PED_BIT_XD]);
    write_ok = entry_in[`PED_BIT_RW]
               || (!user_req_in
                   && !write_protect_enable_in);
    user_ok  = !user_req_in || entry_in[`PED_BIT_US];
    grant    = present && !rsvd_nz && user_ok
               && (!write_req_in || write_ok)
               && (!exec_req_in || exec_ok);
  end

  // next-state fill
  always_comb begin
    state_next = state_reg;
    state_next.resp_valid   = 1'b0;
    state_next.entry_update = 1'b0;
    state_next.lp_support   = `PED_LP_SUPPORT;
    // take a request
    if (req_valid_in) begin
      state_next.resp_valid    = 1'b1;
      state_next.present_ok    = present;
      state_next.malformed     = rsvd_nz;
      state_next.granted       = grant;
      state_next.frame_addr    =
        entry_in[`PED_HAW-1:`PED_FRAME_LSB];
      state_next.frame_is_gpa  = nested_translate_enable_in;
      state_next.exec_allowed  = present && exec_ok;
      state_next.write_allowed = present && write_ok;
      state_next.user_allowed  = present && user_ok;
      state_next.global_page   = global_page_enable_in
                                 && entry_in[`PED_BIT_GLOBAL];
      // memory type index for coherent requesters only
      state_next.attr_valid    = coherent_req_in;
      state_next.attr_idx      = coherent_req_in
        ? {entry_in[`PED_BIT_ATTR], entry_in[`PED_BIT_PCD],
           entry_in[`PED_BIT_PWT]}
        : 3'h0;
      // flag write-back on a granted translation
      state_next.updated_entry = entry_in;
      if (grant) begin
        state_next.updated_entry[`PED_BIT_ACC] = 1'b1;
        if (ext_accessed_flag_enable_in) begin
          state_next.updated_entry[`PED_BIT_EXTACC] = 1'b1;
        end
        if (write_req_in) begin
          state_next.updated_entry[`PED_BIT_DIRTY] = 1'b1;
        end
      end
      state_next.entry_update =
        grant && (state_next.updated_entry != entry_in);
      // second-level execute field
      state_next.sl_exec_allowed =
        !(exec_request_support_in && second_level_exec_enable_in)
        || sl_entry_in[`PED_SL_X];
      // second-level memory type fields
      state_next.sl_emt_valid = mem_type_support_in
                                && mem_type_enable_in;
      state_next.sl_emt = state_next.sl_emt_valid
        ? sl_entry_in[`PED_SL_EMT_MSB:`PED_SL_EMT_LSB]
        : 3'h0;
      state_next.sl_ignore_attr = state_next.sl_emt_valid
                                  && sl_entry_in[`PED_SL_IGNORE_ATTR_BIT];
      // directory level: bit 7 picks large frame
      state_next.sl_large_page = sl_dir_level_in
                                 && sl_entry_in[`PED_SL_PS];
    end
  end

  // state register, cleared by reset even with enable low, otherwise frozen while enable is low
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign resp_valid_out         = state_reg.resp_valid;
  assign present_ok_out         = state_reg.present_ok;
  assign malformed_out          = state_reg.malformed;
  assign granted_out            = state_reg.granted;
  assign frame_addr_out         = state_reg.frame_addr;
  assign frame_is_gpa_out       = state_reg.frame_is_gpa;
  assign exec_allowed_out       = state_reg.exec_allowed;
  assign write_allowed_out      = state_reg.write_allowed;
  assign user_allowed_out       = state_reg.user_allowed;
  assign global_out             = state_reg.global_page;
  assign attr_idx_out           = state_reg.attr_idx;
  assign attr_valid_out         = state_reg.attr_valid;
  assign updated_entry_out      = state_reg.updated_entry;
  assign entry_update_out       = state_reg.entry_update;
  assign sl_exec_allowed_out    = state_reg.sl_exec_allowed;
  assign sl_emt_out             = state_reg.sl_emt;
  assign sl_ignore_attr_out     = state_reg.sl_ignore_attr;
  assign sl_emt_valid_out       = state_reg.sl_emt_valid;
  assign sl_large_page_out      = state_reg.sl_large_page;
  assign large_page_support_out = state_reg.lp_support;

  // checks on the registered answer
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // request taken this cycle
  sequence s_take;
    req_valid_in && clk_en_in;
  endsequence

  // answer cycle
  sequence s_answer;
    resp_valid_out;
  endsequence

  a_deny_exec: assert property (s_take ##0 (no_exec_enable_in
      && entry_in[`PED_BIT_XD]) |=> s_answer ##0 !exec_allowed_out)
    else $error("execute granted with disable bit set");

  a_frame_addr: assert property (s_take |=> s_answer
      ##0 frame_addr_out == $past(entry_in[`PED_HAW-1:`PED_FRAME_LSB]))
    else $error("frame address mismatch");

  a_nested_gpa: assert property (s_take |=>
      frame_is_gpa_out == $past(nested_translate_enable_in))
    else $error("guest physical marking wrong");

  a_ext_accessed: assert property (s_take ##0
      !ext_accessed_flag_enable_in |=>
      updated_entry_out[`PED_BIT_EXTACC] == $past(entry_in[`PED_BIT_EXTACC]))
    else $error("extended accessed touched while disabled");

  a_global_page: assert property (s_take |=> global_out ==
      $past(global_page_enable_in && entry_in[`PED_BIT_GLOBAL]))
    else $error("global marking wrong");

  a_mem_type: assert property (s_take ##0 coherent_req_in |=>
      attr_valid_out && attr_idx_out == $past({entry_in[`PED_BIT_ATTR],
      entry_in[`PED_BIT_PCD], entry_in[`PED_BIT_PWT]}))
    else $error("memory type index wrong");

  a_dirty_set: assert property (s_take ##0 write_req_in
      |=> granted_out |-> updated_entry_out[`PED_BIT_DIRTY]
          && entry_update_out == $past(!entry_in[`PED_BIT_DIRTY]
             || !entry_in[`PED_BIT_ACC]
             || (ext_accessed_flag_enable_in
                 && !entry_in[`PED_BIT_EXTACC])))
    else $error("dirty flag not recorded");

  a_accessed_set: assert property (s_take |=>
      granted_out == updated_entry_out[`PED_BIT_ACC]
      || $past(entry_in[`PED_BIT_ACC]))
    else $error("accessed flag not recorded");

  a_user_refuse: assert property (s_take ##0 user_req_in
      && !entry_in[`PED_BIT_US] |=> !user_allowed_out && !granted_out)
    else $error("user request allowed to supervisor page");

  a_write_deny: assert property (s_take ##0 !entry_in[`PED_BIT_RW]
      |=> write_allowed_out == $past(entry_in[`PED_BIT_P]
          && !user_req_in && !write_protect_enable_in))
    else $error("write permission wrong");

  a_not_present: assert property (s_take ##0 !entry_in[`PED_BIT_P]
      |=> s_answer ##0 !present_ok_out && !granted_out
          && !entry_update_out)
    else $error("non-present entry accepted");

  a_sl_exec: assert property (s_take ##0 (!exec_request_support_in
      || !second_level_exec_enable_in) |=> sl_exec_allowed_out)
    else $error("second-level execute not ignored");

  a_sl_emt: assert property (s_take ##0 (!mem_type_support_in
      || !mem_type_enable_in) |=> !sl_emt_valid_out
      && sl_emt_out == 3'h0 && !sl_ignore_attr_out)
    else $error("second-level memory type not ignored");

  a_lp_support: assert property (1'b1 ##1 clk_en_in |=>
      large_page_support_out == `PED_LP_SUPPORT)
    else $error("large page support field wrong");

  a_malformed: assert property (s_take ##0
      (|entry_in[`PED_RSVD_MSB:`PED_HAW]) |=> malformed_out && !granted_out)
    else $error("reserved bits not flagged");

  a_sl_large: assert property (s_take |=> sl_large_page_out ==
      $past(sl_dir_level_in && sl_entry_in[`PED_SL_PS]))
    else $error("large page decode wrong");

  // the answer drops after one enabled cycle; a frozen cycle keeps it up
  a_resp_pulse: assert property (s_answer ##1 $past(clk_en_in)
      && !$past(req_valid_in) |-> !resp_valid_out)
    else $error("answer held longer than one cycle");

  // write-back strobe stands one enabled cycle only
  a_update_pulse: assert property (entry_update_out ##1 $past(clk_en_in)
      && !$past(req_valid_in) |-> !entry_update_out)
    else $error("write-back strobe held too long");

  // enable low freezes answer valid, frame address, write-back entry and grant
  a_freeze_hold: assert property (!clk_en_in |=> $stable(resp_valid_out)
      && $stable(frame_addr_out) && $stable(updated_entry_out)
      && $stable(granted_out))
    else $error("results moved while enable low");

  // further checks on flags and gating
  a_ext_acc_set: assert property (s_take ##0 ext_accessed_flag_enable_in
      |=> updated_entry_out[`PED_BIT_EXTACC]
          == ($past(entry_in[`PED_BIT_EXTACC]) || granted_out))
    else $error("extended accessed not recorded");

  a_dirty_clean: assert property (s_take ##0 !write_req_in |=>
      updated_entry_out[`PED_BIT_DIRTY] == $past(entry_in[`PED_BIT_DIRTY]))
    else $error("dirty flag set without a write");

  a_present_flag: assert property (s_take |=>
      present_ok_out == $past(entry_in[`PED_BIT_P]))
    else $error("present flag wrong");

  a_exec_gate: assert property (s_take ##0 exec_req_in && no_exec_enable_in
      && entry_in[`PED_BIT_XD] |=> !granted_out)
    else $error("execute request granted on disabled page");

  a_write_user: assert property (s_take ##0 user_req_in && write_req_in
      && !entry_in[`PED_BIT_RW] |=> !granted_out)
    else $error("user write granted on read-only page");

  a_reserved_clear: assert property (s_take ##0
      !(|entry_in[`PED_RSVD_MSB:`PED_HAW]) |=> !malformed_out)
    else $error("clean entry flagged malformed");

  a_sl_small: assert property (s_take ##0 !sl_dir_level_in
      |=> !sl_large_page_out)
    else $error("large page outside directory level");

endmodule : ped_page_entry_decode

// ### tb/ped_table_model.sv
/*
  table memory holding leaf entries as the walker sees them.
  assumes the bench loads entries and the decoder writes back flag updates.
*/
`timescale 1ns/1ps
module ped_table_model (
  // clock
  input  wire logic        clk_in,
  // software load and decoder write-back
  input  wire logic [1:0]  idx_in,
  input  wire logic        ld_in,
  input  wire logic [63:0] ld_data_in,
  input  wire logic        wr_in,
  input  wire logic [63:0] wr_data_in,
  // entry fetched by the walker
  output logic      [63:0] entry_out
);
  logic [63:0] mem [4]; // four leaf entries
  // entries start cleared, so nothing unknown is fetched
  initial mem = '{default: 64'h0000_0000_0000_0000};
  // fetch of the selected entry
  assign entry_out = mem[idx_in];
  // software load wins over the accessed and dirty write-back
  always @(posedge clk_in) begin
    if (ld_in) begin
      mem[idx_in] <= ld_data_in;
    end else if (wr_in) begin
      mem[idx_in] <= wr_data_in;
    end
  end
endmodule : ped_table_model

// ### tb/ped_page_entry_decode_tb.sv
/*
  self-checking bench for the page entry decoder, one task per scenario.
  assumes the decoder, its header and the table model compile first.
*/
`timescale 1ns/1ps
`include "ped_params.svh"
module ped_page_entry_decode_tb;
  // inputs driven at the falling edge
  logic clk, rst_n, en, req, u, w, x, coh, no_exec_enable, nest, ext_accessed_flag_enable, global_page_enable, write_protect_enable;
  logic sld, exec_request_support, second_level_exec_enable, mem_type_support, mem_type_enable, ld;
  logic [63:0] ld_d, sle;
  logic [1:0]  idx;
  // decoder and model outputs
  wire rv, pok, mal, gr, gpa, xa, wa, ua, gl, av, eu, slx, sia, sev, slp;
  wire [`PED_FRAME_W-1:0] fa;
  wire [2:0]  ai, emt;
  wire [63:0] ue, ent;
  wire [1:0]  lps;
  int miscompares, n_tests, cyc;
  ped_page_entry_decode i_ped_page_entry_decode (.clk_in(clk), .rst_n_in(rst_n), .clk_en_in(en),
    .req_valid_in(req), .entry_in(ent), .user_req_in(u), .write_req_in(w), .exec_req_in(x),
    .coherent_req_in(coh), .no_exec_enable_in(no_exec_enable), .nested_translate_enable_in(nest),
    .ext_accessed_flag_enable_in(ext_accessed_flag_enable), .global_page_enable_in(global_page_enable), .write_protect_enable_in(write_protect_enable),
    .sl_entry_in(sle), .sl_dir_level_in(sld), .exec_request_support_in(exec_request_support),
    .second_level_exec_enable_in(second_level_exec_enable), .mem_type_support_in(mem_type_support), .mem_type_enable_in(mem_type_enable),
    .resp_valid_out(rv), .present_ok_out(pok), .malformed_out(mal), .granted_out(gr),
    .frame_addr_out(fa), .frame_is_gpa_out(gpa), .exec_allowed_out(xa), .write_allowed_out(wa),
    .user_allowed_out(ua), .global_out(gl), .attr_idx_out(ai), .attr_valid_out(av),
    .updated_entry_out(ue), .entry_update_out(eu), .sl_exec_allowed_out(slx), .sl_emt_out(emt),
    .sl_ignore_attr_out(sia), .sl_emt_valid_out(sev), .sl_large_page_out(slp),
    .large_page_support_out(lps));
  ped_table_model i_ped_table_model (.clk_in(clk), .idx_in(idx), .ld_in(ld), .ld_data_in(ld_d),
    .wr_in(eu & en), .wr_data_in(ue), .entry_out(ent));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // load entry into the table, then request it; returns with the answer up
  task automatic issue(input logic [63:0] e);
    @(negedge clk) ld = 1'b1;
    ld_d = e;
    @(negedge clk) ld = 1'b0;
    req = 1'b1;
    @(negedge clk) req = 1'b0;
  endtask : issue
  // verdict
  task automatic stop_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // capability field zero in reset, full after release
  task automatic t_reset();
    // three rising edges pass with reset low
    repeat (3) @(negedge clk);
    chk(lps, 2'h0);
    rst_n = 1'b1;
    en = 1'b1;
    @(negedge clk);
    chk(lps, 2'h3);
    $display("t_reset done");
  endtask : t_reset
  // plain grant, frame, accessed write-back, one-cycle answer
  task automatic t_basic();
    issue(64'h0000_8765_4321_0001);
    chk(rv, 1'b1);
    chk(pok, 1'b1);
    chk(fa, 36'h8_7654_3210);
    chk(ue, 64'h0000_8765_4321_0021);
    chk(eu, 1'b1);
    @(negedge clk);
    chk(rv, 1'b0);
    chk(ent, 64'h0000_8765_4321_0021);
    issue(64'h0000_8765_4321_0021);
    chk(eu, 1'b0);
    $display("t_basic done");
  endtask : t_basic
  // all privilege, write and protect combinations
  task automatic t_perm();
    logic us, rw, eg, ew;
    for (int i = 0; i < 32; i++) begin
      {u, w, write_protect_enable, us, rw} = i[4:0];
      issue({61'h0, us, rw, 1'b1});
      ew = rw | (~u & ~write_protect_enable);
      eg = (~u | us) & (~w | ew);
      chk(gr, eg);
      if (!u || us) chk(wa, ew);
      chk(ue, {57'h0, eg & w, eg, 2'h0, us, rw, 1'b1});
    end
    {u, w, write_protect_enable} = 3'h0;
    $display("t_perm done");
  endtask : t_perm
  // execute-disable under the no-exec enable
  task automatic t_exec();
    logic b63;
    for (int i = 0; i < 8; i++) begin
      {no_exec_enable, x, b63} = i[2:0];
      issue({b63, 62'h0, 1'b1});
      chk(xa, !(no_exec_enable && b63));
      chk(gr, !(x && no_exec_enable && b63));
    end
    {no_exec_enable, x} = 2'h0;
    $display("t_exec done");
  endtask : t_exec
  // context flags, attributes, ignored and reserved bits, not present
  task automatic t_misc();
    {ext_accessed_flag_enable, global_page_enable, nest, coh} = 4'hf;
    issue(64'h7FF0_0000_0000_0B99);
    chk(mal, 1'b0);
    chk(gr, 1'b1);
    chk(gl, 1'b1);
    chk(gpa, 1'b1);
    chk({av, ai}, 4'hf);
    chk(ue, 64'h7FF0_0000_0000_0FB9);
    {ext_accessed_flag_enable, global_page_enable, nest, coh} = 4'h0;
    issue(64'h0001_0000_0000_0181);
    chk(mal, 1'b1);
    chk(gr, 1'b0);
    chk(gl, 1'b0);
    chk(gpa, 1'b0);
    chk({av, ai}, 4'h0);
    issue(64'h0000_0000_0000_0006);
    chk({pok, gr, ua}, 3'h0);
    $display("t_misc done");
  endtask : t_misc
  // second-level execute, memory type and page size gating
  task automatic t_sl();
    sle = 64'h0000_0000_0000_00EB;
    for (int i = 0; i < 32; i++) begin
      {exec_request_support, second_level_exec_enable, mem_type_support, mem_type_enable, sld} = i[4:0];
      issue(64'h0000_0000_0000_0001);
      chk(slx, !(exec_request_support && second_level_exec_enable));
      chk(emt, (mem_type_support && mem_type_enable) ? 3'h5 : 3'h0);
      chk({sev, sia}, (mem_type_support && mem_type_enable) ? 2'h3 : 2'h0);
      chk(slp, sld);
    end
    $display("t_sl done");
  endtask : t_sl
  // request with the clock enable low is ignored, results hold
  task automatic t_clken();
    en = 1'b0;
    issue(64'h0000_0000_0000_3001);
    // the last answer stays frozen while the enable is low
    chk(rv, 1'b1);
    chk(fa, 36'h0_0000_0000);
    en = 1'b1;
    $display("t_clken done");
  endtask : t_clken
  // main sequence
  initial begin
    {rst_n, en, req, ld, u, w, x, coh, no_exec_enable, nest, ext_accessed_flag_enable, global_page_enable, write_protect_enable} = 13'h0;
    {sld, exec_request_support, second_level_exec_enable, mem_type_support, mem_type_enable} = 5'h0;
    ld_d = 64'h0000_0000_0000_0000;
    sle = 64'h0000_0000_0000_0000;
    idx = 2'h1;
    t_reset();
    t_basic();
    t_perm();
    t_exec();
    t_misc();
    t_sl();
    t_clken();
    stop_test();
  end
endmodule : ped_page_entry_decode_tb
